// ### hdl/i2crc_defines.vh
// Register offsets, field positions, reset values, response codes and counter width
`ifndef I2CRC_DEFINES_VH
`define I2CRC_DEFINES_VH

`define I2CRC_ADDR_W        4
`define I2CRC_OFF_CTRL      4'h0
`define I2CRC_OFF_RATE      4'h4
`define I2CRC_OFF_STAT      4'h8
`define I2CRC_OFF_MASK      4'hC

`define I2CRC_CTRL_EN       7
`define I2CRC_CTRL_IE       6
`define I2CRC_CTRL_MST      5
`define I2CRC_CTRL_TX       4
`define I2CRC_CTRL_ACK_DISABLE     3
`define I2CRC_CTRL_REPEAT_START_CMD     2

`define I2CRC_CTRL_RST      8'h00
`define I2CRC_RATE_RST      8'h00
`define I2CRC_MASK_RST      8'h00

`define I2CRC_ST_START      0
`define I2CRC_ST_STOP       1
`define I2CRC_ST_RSTART     2
`define I2CRC_ST_ARBL       3
`define I2CRC_ST_BITS       4

`define I2CRC_RESP_OKAY     2'b00
`define I2CRC_RESP_SLVERR   2'b10

`define I2CRC_CNT_W         14

`endif

// ### hdl/i2crc_rate_rom.v
// Clock-rate index decoder: divider and hold counts, registered outputs
`timescale 1ns/1ns
module i2crc_rate_rom (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [5:0]  index,
	output reg  [11:0] divider,
	output reg  [9:0]  sda_hold,
	output reg  [10:0] start_hold,
	output reg  [10:0] stop_hold
);
	reg  [11:0] div_base;
	reg  [9:0]  sda_base;
	reg  [11:0] dv_full;
	wire [2:0]  low;
	wire [2:0]  grp;

	assign low = index[2:0];
	assign grp = index[5:3];

	// Table decodes as base values per low bits scaled per group
	always @* begin
		case (low)
		3'd0: div_base = 12'd20;
		3'd1: div_base = 12'd22;
		3'd2: div_base = 12'd24;
		3'd3: div_base = 12'd26;
		3'd4: div_base = 12'd28;
		3'd5: div_base = 12'd30;
		3'd6: div_base = 12'd34;
		default: div_base = 12'd40;
		endcase
		sda_base = 10'd7;
		dv_full  = dv(index);
	end

	// Table computed per group from base values and functions; compact enough and exact
	always @(posedge aclk) begin
		if (!aresetn) begin
			divider    <= 12'd20;
			sda_hold   <= 10'd7;
			start_hold <= 11'd6;
			stop_hold  <= 11'd11;
		end else begin
			case (grp)
			3'd0: begin
				divider    <= div_base;
				sda_hold   <= sda_base + {8'd0, low[2:1]};
				start_hold <= div_base[11:1] - 11'd4;
				stop_hold  <= div_base[11:1] + 11'd1;
			end
			default: begin
				divider    <= dv_full;
				sda_hold   <= sd(index);
				start_hold <= dv_full[11:1] - st_off(grp);
				stop_hold  <= dv_full[11:1] + 11'd1;
			end
			endcase
		end
	end

	function [11:0] dv;
		input [5:0] i;
		reg [11:0] b;
		begin
			case (i[2:0])
			3'd0: b = 12'd28;
			3'd1: b = 12'd32;
			3'd2: b = 12'd36;
			3'd3: b = 12'd40;
			3'd4: b = 12'd44;
			3'd5: b = 12'd48;
			3'd6: b = 12'd56;
			default: b = 12'd68;
			endcase
			case (i[5:3])
			3'd1: dv = b;
			3'd2: dv = sub2(i[2:0], 12'd48, 12'd8, 12'd104, 12'd128);
			3'd3: dv = sub2(i[2:0], 12'd80, 12'd16, 12'd192, 12'd240);
			3'd4: dv = sub2(i[2:0], 12'd160, 12'd32, 12'd384, 12'd480);
			3'd5: dv = sub2(i[2:0], 12'd320, 12'd64, 12'd768, 12'd960);
			3'd6: dv = sub2(i[2:0], 12'd640, 12'd128, 12'd1536, 12'd1920);
			default: dv = sub2(i[2:0], 12'd1280, 12'd256, 12'd3072, 12'd3840);
			endcase
		end
	endfunction

	function [11:0] sub2;
		input [2:0]  l;
		input [11:0] base;
		input [11:0] step;
		input [11:0] v6;
		input [11:0] v7;
		begin
			case (l)
			3'd6: sub2 = v6;
			3'd7: sub2 = v7;
			default: sub2 = base + step * {9'd0, l};
			endcase
		end
	endfunction

	function [9:0] sd;
		input [5:0] i;
		reg [9:0] a;
		reg [9:0] s;
		begin
			case (i[5:3])
			3'd1: begin a = 10'd7;   s = 10'd2;   end
			3'd2: begin a = 10'd9;   s = 10'd4;   end
			3'd3: begin a = 10'd9;   s = 10'd8;   end
			3'd4: begin a = 10'd17;  s = 10'd16;  end
			3'd5: begin a = 10'd33;  s = 10'd32;  end
			3'd6: begin a = 10'd65;  s = 10'd64;  end
			default: begin a = 10'd129; s = 10'd128; end
			endcase
			sd = a + s * {8'd0, i[2:1]};
			if (i[5:3] == 3'd1 && i[2:1] == 2'd1)
				sd = 10'd9;
		end
	endfunction

	function [10:0] st_off;
		input [2:0] g;
		begin
			case (g)
			3'd1: st_off = 11'd4;
			3'd2: st_off = 11'd6;
			default: st_off = 11'd2;
			endcase
		end
	endfunction
endmodule

// ### hdl/i2crc_line_drv.v
// Open-drain line driver: registered low-drive with enable
`timescale 1ns/1ns
module i2crc_line_drv (
	input  wire aclk,
	input  wire aresetn,
	input  wire drive_low,
	output reg  line_o,
	output reg  line_oe
);
	// Open drain: only ever drives low, releases otherwise
	always @(posedge aclk) begin
		if (!aresetn) begin
			line_o  <= 1'b0;
			line_oe <= 1'b0;
		end else begin
			line_o  <= 1'b0;
			line_oe <= drive_low;
		end
	end
endmodule

// ### hdl/i2crc_top.v
// Serial bus rate generator and primary control register with AXI4-Lite slave
// Summary of operation
// - The 6-bit clock-rate index selects SCL divider and SDA, start and stop hold counts.
// - SCL rate is the bus clock divided by multiplier times the selected divider.
// - Multiplier code 00 gives 1, 01 gives 2, 10 gives 4.
// - SDA hold, start hold and stop hold each last bus period times multiplier times count.
// - Control bit 7 enables the whole module; with it clear the lines are released. Here irq and the arbitration-loss flag are not gated by it.
// - Control bit 6 gates the pending interrupt onto the request output.
// - Master select rising from 0 to 1 issues a start and makes the block master.
// - Master select falling from 1 to 0 issues a stop and returns the block to slave.
// - Transmit select bit 4 sets direction, 1 transmit and 0 receive.
// - In receive acknowledge cycles SDA is driven from ack disable bit 3.
// - Writing 1 to repeat start bit 2 issues a repeated start only while master.
// - The repeat start bit always reads back as 0.
// - A repeated start at an improper point is treated as lost arbitration.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "i2crc_defines.vh"
module i2crc_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        scl_i,
	output wire        scl_o,
	output wire        scl_oe,
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe,
	input  wire        ack_cycle,
	output reg         master_mode,
	output reg         irq
);
	localparam ST_IDLE   = 3'd0;
	localparam ST_START  = 3'd1;
	localparam ST_RUN    = 3'd2;
	localparam ST_STOPLO = 3'd3;
	localparam ST_STOPHI = 3'd4;
	localparam ST_RSHI   = 3'd5;

	reg  [7:0]  ctrl_q;
	reg  [7:0]  rate_q;
	reg  [3:0]  stat_q;
	reg  [3:0]  stat_d;
	reg  [3:0]  mask_q;
	reg  [2:0]  state_q;
	reg  [`I2CRC_CNT_W-1:0] cnt_q;
	reg         scl_low_q;
	reg         sda_low_q;
	reg         phase_q;
	reg  [3:0]  awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         aw_have_q;
	reg         w_have_q;
	reg         repeat_start_cmd_req;
	reg         mst_rise;
	reg         mst_fall;
	reg  [31:0] rd_val;
	wire [11:0] divider;
	wire [9:0]  sda_hold;
	wire [10:0] start_hold;
	wire [10:0] stop_hold;
	wire [2:0]  mul_sh;
	wire [`I2CRC_CNT_W-1:0] half_cnt;
	wire [`I2CRC_CNT_W-1:0] start_cnt;
	wire [`I2CRC_CNT_W-1:0] stop_cnt;
	wire [`I2CRC_CNT_W-1:0] sdah_cnt;
	wire        wr_fire;
	wire        en;

	assign en = ctrl_q[`I2CRC_CTRL_EN];

	i2crc_rate_rom u_rom (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.index      (rate_q[5:0]),
		.divider    (divider),
		.sda_hold   (sda_hold),
		.start_hold (start_hold),
		.stop_hold  (stop_hold)
	);

	// Code 11 is undefined; treated as 4 to keep the bus slow rather than fast
	assign mul_sh = (rate_q[7:6] == 2'b00) ? 3'd0 :
			(rate_q[7:6] == 2'b01) ? 3'd1 : 3'd2;
	assign half_cnt  = ({2'b00, divider} << mul_sh) >> 1;
	assign start_cnt = {3'b000, start_hold} << mul_sh;
	assign stop_cnt  = {3'b000, stop_hold} << mul_sh;
	assign sdah_cnt  = {4'b0000, sda_hold} << mul_sh;

	// Write channel: address and data taken in either order
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `I2CRC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q[3:2] <= 2'd3) ? `I2CRC_RESP_OKAY
								      : `I2CRC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel; one cycle from address to data
	always @* begin
		case ({2'b00, s_axi_araddr[3:2]})
		4'd0: rd_val = {24'h00_0000, ctrl_q & 8'hFB};
		4'd1: rd_val = {24'h00_0000, rate_q};
		4'd2: rd_val = {28'h000_0000, stat_q};
		4'd3: rd_val = {28'h000_0000, mask_q};
		default: rd_val = 32'h0000_0000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `I2CRC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= `I2CRC_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control and rate registers; edges of master select decoded at write
	always @* begin
		repeat_start_cmd_req = 1'b0;
		mst_rise = 1'b0;
		mst_fall = 1'b0;
		if (wr_fire && awaddr_q[3:2] == 2'd0 && wstrb_q[0]) begin
			repeat_start_cmd_req = wdata_q[`I2CRC_CTRL_REPEAT_START_CMD];
			mst_rise = wdata_q[`I2CRC_CTRL_MST] && !ctrl_q[`I2CRC_CTRL_MST];
			mst_fall = !wdata_q[`I2CRC_CTRL_MST] && ctrl_q[`I2CRC_CTRL_MST];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `I2CRC_CTRL_RST;
			rate_q <= `I2CRC_RATE_RST;
			mask_q <= 4'h0;
		end else begin
			if (wr_fire && wstrb_q[0]) begin
				case (awaddr_q[3:2])
				2'd0: ctrl_q <= wdata_q[7:0] & 8'hFB;
				2'd1: rate_q <= wdata_q[7:0];
				2'd3: mask_q <= wdata_q[3:0];
				default: ;
				endcase
			end
			// Mode drops back to slave on lost arbitration or disable
			if (stat_d[`I2CRC_ST_ARBL] && !stat_q[`I2CRC_ST_ARBL] || !en)
				ctrl_q[`I2CRC_CTRL_MST] <= 1'b0;
		end
	end

	// SCL and condition sequencer
	always @(posedge aclk) begin
		if (!aresetn || !en) begin
			state_q   <= ST_IDLE;
			cnt_q     <= {`I2CRC_CNT_W{1'b0}};
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			phase_q   <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				scl_low_q <= 1'b0;
				// Slave receiver acknowledges from the same control bits
				sda_low_q <= ack_cycle && !ctrl_q[`I2CRC_CTRL_TX] &&
					     !ctrl_q[`I2CRC_CTRL_ACK_DISABLE];
				if (mst_rise) begin
					sda_low_q <= 1'b1;
					cnt_q     <= start_cnt;
					state_q   <= ST_START;
				end
			end
			ST_START: begin
				// Stop asked during the start hold must not leave the clock running
				if (mst_fall) begin
					scl_low_q <= 1'b1;
					sda_low_q <= 1'b1;
					cnt_q     <= half_cnt;
					state_q   <= ST_STOPLO;
				end else if (cnt_q <= 1) begin
					scl_low_q <= 1'b1;
					sda_low_q <= 1'b0;
					phase_q   <= 1'b0;
					cnt_q     <= half_cnt;
					state_q   <= ST_RUN;
				end else
					cnt_q <= cnt_q - 1'b1;
			end
			ST_RUN: begin
				if (mst_fall) begin
					scl_low_q <= 1'b1;
					sda_low_q <= 1'b1;
					cnt_q     <= half_cnt;
					state_q   <= ST_STOPLO;
				end else if (repeat_start_cmd_req && !scl_low_q) begin
					sda_low_q <= 1'b1;
					cnt_q     <= start_cnt;
					state_q   <= ST_START;
				end else if (cnt_q <= 1) begin
					scl_low_q <= !scl_low_q;
					cnt_q     <= half_cnt;
				end else begin
					cnt_q <= cnt_q - 1'b1;
					// Data changes only after the hold from the falling edge
					if (scl_low_q && half_cnt - cnt_q == sdah_cnt)
						sda_low_q <= ack_cycle && !ctrl_q[`I2CRC_CTRL_TX] &&
							     !ctrl_q[`I2CRC_CTRL_ACK_DISABLE];
				end
			end
			ST_STOPLO: begin
				if (cnt_q <= 1) begin
					scl_low_q <= 1'b0;
					cnt_q     <= stop_cnt;
					state_q   <= ST_STOPHI;
				end else
					cnt_q <= cnt_q - 1'b1;
			end
			ST_STOPHI: begin
				if (cnt_q <= 1) begin
					sda_low_q <= 1'b0;
					state_q   <= ST_IDLE;
				end else
					cnt_q <= cnt_q - 1'b1;
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Status: set wins over write-one-to-clear
	always @* begin
		stat_d = stat_q;
		if (wr_fire && awaddr_q[3:2] == 2'd2 && wstrb_q[0])
			stat_d = stat_q & ~wdata_q[3:0];
		if (state_q == ST_IDLE && mst_rise && en)
			stat_d[`I2CRC_ST_START] = 1'b1;
		if (state_q == ST_STOPHI && cnt_q <= 1)
			stat_d[`I2CRC_ST_STOP] = 1'b1;
		if (state_q == ST_RUN && repeat_start_cmd_req && !mst_fall && !scl_low_q)
			stat_d[`I2CRC_ST_RSTART] = 1'b1;
		// Repeat start outside master run, or mid low phase, is an arbitration loss
		if (repeat_start_cmd_req && !mst_rise && (state_q != ST_RUN || scl_low_q))
			stat_d[`I2CRC_ST_ARBL] = 1'b1;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			stat_q      <= 4'h0;
			irq         <= 1'b0;
			master_mode <= 1'b0;
		end else begin
			stat_q      <= stat_d;
			irq         <= ctrl_q[`I2CRC_CTRL_IE] && |(stat_q & mask_q);
			master_mode <= ctrl_q[`I2CRC_CTRL_MST] && en;
		end
	end

	i2crc_line_drv u_scl (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.drive_low (scl_low_q && en),
		.line_o    (scl_o),
		.line_oe   (scl_oe)
	);

	i2crc_line_drv u_sda (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.drive_low (sda_low_q && en),
		.line_o    (sda_o),
		.line_oe   (sda_oe)
	);
endmodule

// ### test/i2crc_peer.sv
// Far-side model: other bus parties and the pull-ups on both lines
`timescale 1ns/1ns
module i2crc_peer (
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic hold_scl,
	input  wire logic ack_slot,
	output wire logic scl_i,
	output wire logic sda_i,
	output wire logic ack_cycle
);
	// Wired AND; a released line floats to the pull-up level
	assign scl_i     = !(scl_oe || hold_scl);
	assign sda_i     = !sda_oe;
	// Remote master marks its acknowledge slot only while SCL is low
	assign ack_cycle = ack_slot && !scl_i;
endmodule

// ### test/i2crc_chk_asserts.sv
// Port-level assertions for the rate generator and control block
`timescale 1ns/1ns
module i2crc_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        ack_cycle,
	input wire logic        master_mode,
	input wire logic        irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_quiet: assert property (disable iff (1'b0)
		!aresetn |=> !scl_oe && !sda_oe && !master_mode && !irq) else $error("reset left outputs set");
	a_open_drain: assert property (!scl_o && !sda_o)
		else $error("line output not low");
	a_start_first: assert property ($rose(master_mode) |-> ##[0:3] (sda_oe && !scl_oe))
		else $error("no start on master entry");
	a_start_hold: assert property ($rose(sda_oe) && !scl_oe && !ack_cycle |-> !scl_oe[*6])
		else $error("start hold too short");
	a_scl_phase: assert property (master_mode && $changed(scl_oe) |=> $stable(scl_oe)[*8])
		else $error("scl phase too short");
	a_stop_only: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) && !ack_cycle
		|-> !master_mode) else $error("stop while master");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	c_start: cover property ($rose(master_mode));
	c_stop: cover property ($fell(master_mode));
	c_irq: cover property ($rose(irq));
endmodule
bind i2crc_top i2crc_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .scl_o, .scl_oe, .sda_o, .sda_oe,
	.ack_cycle, .master_mode, .irq);

// ### test/tb_top.sv
// Self-checking bench for the rate generator and control block
`timescale 1ns/1ns
`include "i2crc_defines.vh"
module tb_top;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	logic        hold_scl = 0, ack_slot = 0, scl_p = 0, sda_p = 0;
	logic [3:0]  awa = 0, ara = 0, ws = 4'hf;
	logic [31:0] wd = 0, rd, v, got;
	logic        awr, wr, bv, arr, rv, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, ack_cycle;
	logic        master_mode, irq;
	logic [1:0]  br, rr;
	logic [33:0] tb;
	int          fail_count = 0, n_compared = 0, n, k, cyc = 0, t_scl = 0, t_sda = 0, t0;
	i2crc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .scl_i(scl_i), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .ack_cycle(ack_cycle),
		.master_mode(master_mode), .irq(irq));
	i2crc_peer u_peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_scl(hold_scl),
		.ack_slot(ack_slot), .scl_i(scl_i), .sda_i(sda_i), .ack_cycle(ack_cycle));
	always #4 aclk = ~aclk;
	// Release times kept in the background, a stop may begin during the write
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		scl_p <= scl_oe;
		sda_p <= sda_oe;
		if (scl_p && !scl_oe)
			t_scl <= cyc;
		if (sda_p && !sda_oe)
			t_sda <= cyc;
	end
	function automatic int mul(input logic [1:0] c);
		return c == 2'h0 ? 1 : c == 2'h1 ? 2 : 4;
	endfunction
	function automatic logic [33:0] tab(input logic [5:0] i);
		case (i)
			6'h00: return {12'h014, 11'h006, 11'h00b};
			6'h07: return {12'h028, 11'h010, 11'h015};
			6'h14: return {12'h050, 11'h022, 11'h029};
			6'h1f: return {12'h0f0, 11'h076, 11'h079};
			default: return {12'hf00, 11'h77e, 11'h781};
		endcase
	endfunction
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task tick;
		@(posedge aclk);
		#1;
	endtask
	task axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		brdy <= 1;
		do begin
			@(posedge aclk);
			if (awr)
				awv <= 0;
			if (wr)
				wv <= 0;
		end while (awv && !awr || wv && !wr);
		do @(posedge aclk); while (!bv);
		chk("bresp", {30'h0, br}, 32'h0000_0000);
		brdy <= 0;
	endtask
	task axi_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		rrdy <= 1;
		do @(posedge aclk); while (!arr);
		arv <= 0;
		do @(posedge aclk); while (!rv);
		d = rd;
		rrdy <= 0;
	endtask
	task await(input logic sel, input logic e);
		k = 0;
		while ((sel ? irq : sda_oe) !== e && k < 12) begin
			tick;
			k++;
		end
		chk(sel ? "irq" : "sda_oe", {31'h0, sel ? irq : sda_oe}, {31'h0, e});
	endtask
	task rate_case(input logic [5:0] i, input logic [1:0] mc);
		tb = tab(i);
		axi_wr(`I2CRC_OFF_RATE, {24'h0, mc, i});
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_00b0); // transmit held for the address cycle
		#1;
		while (!sda_oe)
			tick;
		n = 0;
		while (!scl_oe) begin
			tick;
			n++;
		end
		chk("start_hold", n, 32'(tb[21:11]) * mul(mc));
		chk("master_mode", {31'h0, master_mode}, 32'h0000_0001);
		n = 0;
		while (scl_oe) begin
			tick;
			n++;
		end
		while (!scl_oe) begin
			tick;
			n++;
		end
		chk("scl_period", n, 32'(tb[33:22]) * mul(mc));
		if (i == 6'h3f) begin
			while (scl_oe)
				tick;
			axi_wr(`I2CRC_OFF_CTRL, 32'h0000_00b4);
			#1;
			chk("restart_sda", {31'h0, sda_oe}, 32'h0000_0001);
			while (!scl_oe)
				tick;
		end
		t0 = cyc;
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_0090);
		while (master_mode || sda_oe || scl_oe || t_sda <= t0)
			tick;
		chk("stop_hold", t_sda - t_scl, 32'(tb[10:0]) * mul(mc));
		repeat (20) tick;
	endtask
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge aclk);
		fail_count++;
		summarize;
	end
	initial begin
		v = $urandom(3);
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		for (int a = 0; a < 16; a += 4) begin
			axi_rd(4'(a), v);
			chk("reset_value", v, 32'h0000_0000);
		end
		repeat (8) begin
			v = $urandom & 32'h0000_00dc;
			axi_wr(`I2CRC_OFF_CTRL, v);
			axi_rd(`I2CRC_OFF_CTRL, got);
			chk("ctrl", got, v & 32'h0000_00d8);
			v = $urandom & 32'h0000_00ff;
			axi_wr(`I2CRC_OFF_RATE, v);
			axi_rd(`I2CRC_OFF_RATE, got);
			chk("rate", got, v);
		end
		// A write without the low byte strobe must leave the register alone
		axi_wr(`I2CRC_OFF_RATE, 32'h0000_0012);
		ws <= 4'h0;
		axi_wr(`I2CRC_OFF_RATE, 32'h0000_002d);
		ws <= 4'hf;
		axi_rd(`I2CRC_OFF_RATE, got);
		chk("rate_strobe", got, 32'h0000_0012);
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_0020);
		axi_wr(`I2CRC_OFF_STAT, 32'h0000_000f);
		repeat (20) tick;
		chk("master_off", {30'h0, master_mode, sda_oe}, 32'h0000_0000);
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_0084);
		axi_rd(`I2CRC_OFF_STAT, v);
		chk("status_arbl", v, 32'h0000_0008);
		axi_wr(`I2CRC_OFF_STAT, 32'h0000_000f);
		rate_case(6'h00, 2'h0);
		rate_case(6'h07, 2'h1);
		rate_case(6'h14, 2'h2);
		rate_case(6'h1f, 2'h3);
		rate_case(6'h3f, 2'h0);
		axi_rd(`I2CRC_OFF_STAT, v);
		chk("status_seq", v, 32'h0000_0007);
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_00c0);
		await(1, 0);
		axi_wr(`I2CRC_OFF_MASK, 32'h0000_0001);
		await(1, 1);
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_0080);
		await(1, 0);
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_00c0);
		await(1, 1);
		axi_wr(`I2CRC_OFF_STAT, 32'h0000_0001);
		await(1, 0);
		// Slave receive, direction chosen as a writing master expects
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_0080);
		@(posedge aclk);
		hold_scl <= 1;
		ack_slot <= 1;
		await(0, 1);
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_0088);
		await(0, 0);
		axi_wr(`I2CRC_OFF_CTRL, 32'h0000_0090);
		repeat (4) tick;
		await(0, 0);
		@(posedge aclk);
		hold_scl <= 0;
		ack_slot <= 0;
		summarize;
	end
endmodule
